// [pkg/iisf_pkg.sv]
// Shared types, coefficients and helpers for the interpolation and inverse sinc chain.
package iisf_pkg;

   // ----------------------------------------------------------------
   // Widths and sample carrier
   // ----------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int ACC_W = 40;
   localparam int COEF_W = 18;
   localparam int CNT_W = 4;
   localparam int NSTAGE = 4;

   typedef struct packed {
      logic signed [DATA_W-1:0] i;
      logic signed [DATA_W-1:0] q;
   } iisf_iq_t;

   typedef enum logic [1:0] {
      IISF_X2 = 2'h0,
      IISF_X4 = 2'h1,
      IISF_X8 = 2'h2,
      IISF_X16 = 2'h3
   } iisf_factor_t;

   localparam logic signed [ACC_W-1:0] SAT_MAX = 40'sh0000007FFF;
   localparam logic signed [ACC_W-1:0] SAT_MIN = -40'sh0000008000;

   // ----------------------------------------------------------------
   // Half-band outer taps, outermost first; centre is 2**SHIFT
   // ----------------------------------------------------------------
   // Together these tables set the composite band edges and ripple.
   localparam int HB0_K = 15;
   localparam int HB0_SHIFT = 16;
   localparam logic signed [COEF_W-1:0] HB0_COEF [HB0_K] = '{
      18'sh00006, -18'sh00013, 18'sh0002F, -18'sh00064, 18'sh000C0,
      -18'sh00156, 18'sh0023C, -18'sh00392, 18'sh00581, -18'sh00847,
      18'sh00C50, -18'sh01279, 18'sh01CFC, -18'sh03416, 18'sh0A237};
   localparam int HB1_K = 6;
   localparam int HB1_SHIFT = 14;
   localparam logic signed [COEF_W-1:0] HB1_COEF [HB1_K] = '{
      -18'sh0000C, 18'sh00054, -18'sh00150, 18'sh003EE, -18'sh00A83, 18'sh0279D};
   localparam int HB2_K = 3;
   localparam int HB2_SHIFT = 11;
   localparam logic signed [COEF_W-1:0] HB2_COEF [HB2_K] = '{
      18'sh0001D, -18'sh000D6, 18'sh004B9};
   localparam int HB3_K = 3;
   localparam int HB3_SHIFT = 8;
   localparam logic signed [COEF_W-1:0] HB3_COEF [HB3_K] = '{
      18'sh00003, -18'sh00019, 18'sh00096};

   // ----------------------------------------------------------------
   // Inverse sinc equaliser
   // ----------------------------------------------------------------
   localparam int ISINC_TAPS = 9;
   localparam int ISINC_CTR = 4;
   localparam int ISINC_SHIFT = 9;
   localparam logic signed [COEF_W-1:0] ISINC_CENTRE = 18'sh00250;
   localparam logic signed [COEF_W-1:0] ISINC_COEF [ISINC_CTR] = '{
      18'sh00001, -18'sh00004, 18'sh0000D, -18'sh00032};

   // ----------------------------------------------------------------
   // Round half up, shift down and clip to the data width
   // ----------------------------------------------------------------
   function automatic logic signed [DATA_W-1:0] rnd_sat(
      input logic signed [ACC_W-1:0] acc,
      input int sh
   );
      logic signed [ACC_W-1:0] half;
      logic signed [ACC_W-1:0] r;
      half = '0;
      half[sh-1] = 1'b1;
      r = (acc + half) >>> sh;
      if (r > SAT_MAX) begin
         r = SAT_MAX;
      end else if (r < SAT_MIN) begin
         r = SAT_MIN;
      end
      return r[DATA_W-1:0];
   endfunction

endpackage

// [hdl/iisf_halfband.sv]
// One zero-stuffing half-band interpolation stage for I and Q.
`timescale 1ns/1ps
module iisf_halfband #(
   parameter int K = 3,
   parameter int SHIFT = 8,
   parameter logic signed [iisf_pkg::COEF_W-1:0] COEF [K] = '{default: '0}
) (
   input logic clk_i,
   input logic srst_i,
   input logic en_i,
   input logic load_i,
   input iisf_pkg::iisf_iq_t din_i,
   output iisf_pkg::iisf_iq_t dout_o
);

   localparam int L = 4 * K - 1;
   localparam int CTR = 2 * K - 1;

   iisf_pkg::iisf_iq_t taps_r [L];
   iisf_pkg::iisf_iq_t taps_nxt [L];
   iisf_pkg::iisf_iq_t dout_r;
   iisf_pkg::iisf_iq_t dout_nxt;
   iisf_pkg::iisf_iq_t ctr_smp;
   logic signed [iisf_pkg::ACC_W-1:0] acc_i;
   logic signed [iisf_pkg::ACC_W-1:0] acc_q;
   logic even_zero;

   // ----------------------------------------------------------------
   // Filter at the doubled rate
   // ----------------------------------------------------------------
   // Zero taps are skipped and mirrored taps share one multiplier per channel.
   always_comb begin
      taps_nxt = taps_r;
      dout_nxt = dout_r;
      ctr_smp = taps_r[CTR];
      even_zero = 1'b1;
      acc_i = iisf_pkg::ACC_W'(taps_r[CTR].i) <<< SHIFT;
      acc_q = iisf_pkg::ACC_W'(taps_r[CTR].q) <<< SHIFT;
      for (int t = 0; t < K; t++) begin
         acc_i = acc_i + iisf_pkg::ACC_W'(COEF[t]) * (iisf_pkg::ACC_W'(taps_r[2*t].i)
            + iisf_pkg::ACC_W'(taps_r[L-1-2*t].i));
         acc_q = acc_q + iisf_pkg::ACC_W'(COEF[t]) * (iisf_pkg::ACC_W'(taps_r[2*t].q)
            + iisf_pkg::ACC_W'(taps_r[L-1-2*t].q));
         even_zero = even_zero && (taps_r[2*t] == '0) && (taps_r[L-1-2*t] == '0);
      end
      if (en_i) begin
         for (int t = L - 1; t > 0; t--) begin
            taps_nxt[t] = taps_r[t-1];
         end
         taps_nxt[0] = load_i ? din_i : '0;
         dout_nxt.i = iisf_pkg::rnd_sat(acc_i, SHIFT);
         dout_nxt.q = iisf_pkg::rnd_sat(acc_q, SHIFT);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         taps_r <= '{default: '0};
         dout_r <= '0;
      end else begin
         taps_r <= taps_nxt;
         dout_r <= dout_nxt;
      end
   end

   assign dout_o = dout_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   a_stuff_zero: assert property (
      en_i && !load_i |=> taps_r[0] == '0)
      else $error("Stuffing phase did not insert a zero sample.");

   // The reset term keeps a one-edge reset from comparing cleared taps with stale ones.
   a_centre_pass: assert property (
      !srst_i && en_i && even_zero |=> dout_o == $past(ctr_smp))
      else $error("Centre phase did not pass the sample unchanged.");

   a_idle_hold: assert property (
      !srst_i && !en_i |=> dout_o == $past(dout_o))
      else $error("Idle stage changed its output.");

endmodule

// [hdl/iisf_top.sv]
// Half-band interpolation chain with optional inverse sinc equaliser.
// Operation
// - Cascaded doubling stages give 2x to 16x.
// - Composite transition band 0.4 to 0.6 input rate.
// - Ripple under 0.001 dB, stop band over 90 dB.
// - Optional symmetric 9-tap equaliser at DAC rate.
// - Equaliser flattens hold roll-off within 0.03 dB.
// - First stage: 59 taps, centre 65536.
// - Second stage: 23 taps, centre 16384.
// - Third, fourth stages: 11 taps each.
`timescale 1ns/1ps
module iisf_top (
   input logic clk_i,
   input logic srst_i,
   input iisf_pkg::iisf_factor_t interp_sel_i,
   input logic isinc_en_i,
   input iisf_pkg::iisf_iq_t in_data_i,
   input logic in_valid_i,
   output logic in_ready_o,
   output iisf_pkg::iisf_iq_t out_data_o,
   output logic out_valid_o
);

   localparam int NST = iisf_pkg::NSTAGE;
   localparam int CNT_W = iisf_pkg::CNT_W;
   localparam int NEQ = iisf_pkg::ISINC_TAPS;
   localparam int ECTR = iisf_pkg::ISINC_CTR;
   localparam int GAP_W = CNT_W + 1;

   function automatic logic [CNT_W-1:0] low_mask(input int m);
      return CNT_W'((1 << m) - 1);
   endfunction

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic ready_r;
   logic ready_nxt;
   logic valid_r;
   logic valid_nxt;
   logic [GAP_W-1:0] gap_r;
   logic [GAP_W-1:0] gap_nxt;
   logic gap_ok_r;
   logic gap_ok_nxt;
   iisf_pkg::iisf_factor_t sel_q_r;
   logic [NST-1:0] en;
   logic [NST-1:0] load;
   int nst;
   iisf_pkg::iisf_iq_t din [NST];
   iisf_pkg::iisf_iq_t hb_out [NST];
   iisf_pkg::iisf_iq_t chain_out;
   iisf_pkg::iisf_iq_t eq_r [NEQ];
   iisf_pkg::iisf_iq_t eq_nxt [NEQ];
   iisf_pkg::iisf_iq_t out_r;
   iisf_pkg::iisf_iq_t out_nxt;
   iisf_pkg::iisf_iq_t eq_ctr;
   logic signed [iisf_pkg::ACC_W-1:0] eq_acc_i;
   logic signed [iisf_pkg::ACC_W-1:0] eq_acc_q;
   logic eq_flat;

   // ----------------------------------------------------------------
   // Rate sequencer
   // ----------------------------------------------------------------
   // The last active stage runs every clock; each earlier stage runs at half the rate of
   // the one after it. The sequencer free-runs, so a factor change takes effect on the fly
   // and may corrupt the samples in flight until the chain refills.
   always_comb begin
      nst = int'(interp_sel_i) + 1;
      cnt_nxt = cnt_r + CNT_W'(1);
      ready_nxt = (cnt_nxt & low_mask(nst)) == '0;
      valid_nxt = 1'b1;
      gap_nxt = ready_r ? GAP_W'(1) : ((gap_r == '1) ? gap_r : gap_r + GAP_W'(1));
      gap_ok_nxt = (ready_r || gap_ok_r) && (interp_sel_i == sel_q_r);
      for (int k = 0; k < NST; k++) begin
         en[k] = 1'b0;
         load[k] = 1'b0;
         if (k < nst) begin
            en[k] = (cnt_r & low_mask(nst - 1 - k)) == '0;
            load[k] = (k == 0) ? ready_r : ((cnt_r & low_mask(nst - k)) == '0);
         end
      end
      din[0] = in_valid_i ? in_data_i : '0;
      for (int k = 1; k < NST; k++) begin
         din[k] = hb_out[k-1];
      end
      chain_out = hb_out[nst-1];
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_r <= '0;
         ready_r <= 1'b0;
         valid_r <= 1'b0;
         gap_r <= '0;
         gap_ok_r <= 1'b0;
         sel_q_r <= iisf_pkg::IISF_X2;
      end else begin
         cnt_r <= cnt_nxt;
         ready_r <= ready_nxt;
         valid_r <= valid_nxt;
         gap_r <= gap_nxt;
         gap_ok_r <= gap_ok_nxt;
         sel_q_r <= interp_sel_i;
      end
   end

   // ----------------------------------------------------------------
   // Half-band stages
   // ----------------------------------------------------------------
   iisf_halfband #(
      .K(iisf_pkg::HB0_K),
      .SHIFT(iisf_pkg::HB0_SHIFT),
      .COEF(iisf_pkg::HB0_COEF)
   ) u_first_halfband_stage (
      .clk_i(clk_i), .srst_i(srst_i), .en_i(en[0]), .load_i(load[0]),
      .din_i(din[0]), .dout_o(hb_out[0])
   );

   iisf_halfband #(
      .K(iisf_pkg::HB1_K),
      .SHIFT(iisf_pkg::HB1_SHIFT),
      .COEF(iisf_pkg::HB1_COEF)
   ) u_second_halfband_stage (
      .clk_i(clk_i), .srst_i(srst_i), .en_i(en[1]), .load_i(load[1]),
      .din_i(din[1]), .dout_o(hb_out[1])
   );

   iisf_halfband #(
      .K(iisf_pkg::HB2_K),
      .SHIFT(iisf_pkg::HB2_SHIFT),
      .COEF(iisf_pkg::HB2_COEF)
   ) u_third_halfband_stage (
      .clk_i(clk_i), .srst_i(srst_i), .en_i(en[2]), .load_i(load[2]),
      .din_i(din[2]), .dout_o(hb_out[2])
   );

   iisf_halfband #(
      .K(iisf_pkg::HB3_K),
      .SHIFT(iisf_pkg::HB3_SHIFT),
      .COEF(iisf_pkg::HB3_COEF)
   ) u_fourth_halfband_stage (
      .clk_i(clk_i), .srst_i(srst_i), .en_i(en[3]), .load_i(load[3]),
      .din_i(din[3]), .dout_o(hb_out[3])
   );

   // ----------------------------------------------------------------
   // Inverse sinc equaliser
   // ----------------------------------------------------------------
   // Bypass takes the centre tap so that the delay does not jump when the equaliser is
   // switched. Its gain exceeds one, so hot inputs clip here rather than wrap.
   always_comb begin
      eq_nxt[0] = chain_out;
      for (int t = 1; t < NEQ; t++) begin
         eq_nxt[t] = eq_r[t-1];
      end
      eq_ctr = eq_r[ECTR];
      eq_flat = 1'b1;
      eq_acc_i = iisf_pkg::ACC_W'(eq_r[ECTR].i) * iisf_pkg::ACC_W'(iisf_pkg::ISINC_CENTRE);
      eq_acc_q = iisf_pkg::ACC_W'(eq_r[ECTR].q) * iisf_pkg::ACC_W'(iisf_pkg::ISINC_CENTRE);
      for (int t = 0; t < ECTR; t++) begin
         eq_acc_i = eq_acc_i + iisf_pkg::ACC_W'(iisf_pkg::ISINC_COEF[t])
            * (iisf_pkg::ACC_W'(eq_r[t].i) + iisf_pkg::ACC_W'(eq_r[NEQ-1-t].i));
         eq_acc_q = eq_acc_q + iisf_pkg::ACC_W'(iisf_pkg::ISINC_COEF[t])
            * (iisf_pkg::ACC_W'(eq_r[t].q) + iisf_pkg::ACC_W'(eq_r[NEQ-1-t].q));
         eq_flat = eq_flat && (eq_r[t] == eq_ctr) && (eq_r[NEQ-1-t] == eq_ctr);
      end
      if (isinc_en_i) begin
         out_nxt.i = iisf_pkg::rnd_sat(eq_acc_i, iisf_pkg::ISINC_SHIFT);
         out_nxt.q = iisf_pkg::rnd_sat(eq_acc_q, iisf_pkg::ISINC_SHIFT);
      end else begin
         out_nxt = eq_ctr;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         eq_r <= '{default: '0};
         out_r <= '0;
      end else begin
         eq_r <= eq_nxt;
         out_r <= out_nxt;
      end
   end

   assign in_ready_o = ready_r;
   assign out_data_o = out_r;
   assign out_valid_o = valid_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_quiet3;
      !in_ready_o [*3];
   endsequence

   a_ready_gap: assert property (
      in_ready_o && gap_ok_r && (interp_sel_i == sel_q_r) |-> gap_r == GAP_W'(1 << nst))
      else $error("Input request spacing differs from the interpolation factor.");

   a_ready_quiet: assert property (
      in_ready_o && (interp_sel_i == iisf_pkg::IISF_X16) && (sel_q_r == interp_sel_i)
      ##1 (interp_sel_i == sel_q_r) |-> s_quiet3)
      else $error("Input requested too soon at 16x.");

   a_isinc_bypass: assert property (
      !srst_i && !isinc_en_i |=> out_data_o == $past(eq_ctr))
      else $error("Bypassed equaliser did not pass the centre sample.");

   a_isinc_dc: assert property (
      !srst_i && isinc_en_i && eq_flat |=> out_data_o == $past(eq_ctr))
      else $error("Equaliser gain at zero frequency is not unity.");

   a_out_valid: assert property (
      $fell(srst_i) |=> out_valid_o ##1 out_valid_o)
      else $error("Output stream is not valid every cycle after reset.");

endmodule

// [test/iisf_src_model.sv]
// Upstream sample source that hands one word to the chain on each ready pulse.
`timescale 1ns/1ps
module iisf_src_model (
   input wire logic clk_i,
   input wire logic ready_i,
   output iisf_pkg::iisf_iq_t data_o,
   output logic valid_o
);
   iisf_pkg::iisf_iq_t q_s[$];
   iisf_pkg::iisf_iq_t rep_val;
   logic rep_on;
   int take_cyc;
   int cyc;

   initial begin
      data_o = 32'h0;
      valid_o = 1'b0;
      rep_val = 32'h0;
      rep_on = 1'b0;
      take_cyc = -1;
      cyc = 0;
   end

   task automatic push(input iisf_pkg::iisf_iq_t v);
      q_s.push_back(v);
   endtask

   // --------------------------------------------------------------
   // Presentation
   // --------------------------------------------------------------
   // An idle source inverts its data word on every clock, so a stale value never looks valid.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (ready_i && valid_o && q_s.size() > 0) begin
         void'(q_s.pop_front());
         take_cyc <= cyc;
      end
      if (q_s.size() > 0) begin
         data_o <= q_s[0];
         valid_o <= 1'b1;
      end else if (rep_on) begin
         data_o <= rep_val;
         valid_o <= 1'b1;
      end else begin
         data_o <= ~data_o;
         valid_o <= 1'b0;
      end
   end
endmodule

// [test/testbench.sv]
// Self-checking bench for the interpolation chain and inverse sinc equaliser.
`timescale 1ns/1ps
module testbench;
   typedef struct {
      iisf_pkg::iisf_factor_t sel;
      logic eq;
      iisf_pkg::iisf_iq_t v;
   } iisf_row_t;
   localparam longint AMP = 64'sh4000;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   iisf_pkg::iisf_factor_t interp_sel_i = iisf_pkg::IISF_X2;
   logic isinc_en_i = 1'b0;
   iisf_pkg::iisf_iq_t in_data_i;
   logic in_valid_i;
   logic in_ready_o;
   iisf_pkg::iisf_iq_t out_data_o;
   logic out_valid_o;
   int bad_count = 0;
   int checked = 0;
   iisf_pkg::iisf_iq_t cap[160];
   iisf_row_t rows[8] = '{
      '{iisf_pkg::IISF_X2, 1'b0, 32'h7FFF8000}, '{iisf_pkg::IISF_X2, 1'b1, 32'h12340ABC},
      '{iisf_pkg::IISF_X4, 1'b0, 32'h80007FFF}, '{iisf_pkg::IISF_X4, 1'b1, 32'h7FFF8000},
      '{iisf_pkg::IISF_X8, 1'b0, 32'h00010001}, '{iisf_pkg::IISF_X8, 1'b1, 32'hFFFF0001},
      '{iisf_pkg::IISF_X16, 1'b0, 32'h4000C000}, '{iisf_pkg::IISF_X16, 1'b1, 32'h7FFF8000}};

   always #4 clk_i = ~clk_i;

   iisf_top iisf_top_inst (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .interp_sel_i(interp_sel_i),
      .isinc_en_i(isinc_en_i),
      .in_data_i(in_data_i),
      .in_valid_i(in_valid_i),
      .in_ready_o(in_ready_o),
      .out_data_o(out_data_o),
      .out_valid_o(out_valid_o)
   );

   iisf_src_model src_inst (
      .clk_i(clk_i),
      .ready_i(in_ready_o),
      .data_o(in_data_i),
      .valid_o(in_valid_i)
   );

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic timeout();
      bad_count++;
      $display("unexpected wait limit at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      complete_run();
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic do_reset(input iisf_pkg::iisf_factor_t sel, input logic eq, input int n);
      @(posedge clk_i);
      srst_i <= 1'b1;
      interp_sel_i <= sel;
      isinc_en_i <= eq;
      repeat (n) @(posedge clk_i);
      srst_i <= 1'b0;
   endtask

   task automatic wait_ready(output int n);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (in_ready_o !== 1'b1 && n < 40);
      if (n >= 40) timeout();
   endtask

   // Rounding is half up, as chosen for the chain, then clipped to 16 bits.
   function automatic logic [15:0] rnd(input longint a, input int sh);
      longint r;
      r = (a + (longint'(1) <<< (sh - 1))) >>> sh;
      if (r > 32767) r = 32767;
      if (r < -32768) r = -32768;
      return r[15:0];
   endfunction

   function automatic longint yv(input int k, input longint s);
      longint h;
      if (k == 29) h = 65536;
      else if (k < 0 || k > 58 || k % 2 == 1) return 0;
      else h = longint'(iisf_pkg::HB0_COEF[(k < 29) ? k / 2 : (58 - k) / 2]);
      return longint'($signed(rnd(h * s, 16)));
   endfunction

   function automatic logic [15:0] ev(input int k, input longint s, input logic eq);
      longint a;
      a = 0;
      if (!eq) a = yv(k, s) <<< 9;
      else for (int j = 0; j < 9; j++)
         a += ((j == 4) ? 592 : longint'(iisf_pkg::ISINC_COEF[(j < 4) ? j : 8 - j])) * yv(k + 4 - j, s);
      return rnd(a, 9);
   endfunction

   task automatic run_imp(input logic eq, input longint amp, inout int lat);
      int n;
      src_inst.rep_on = 1'b0;
      src_inst.take_cyc = -1;
      do_reset(iisf_pkg::IISF_X2, eq, 2);
      src_inst.push({16'(amp), 16'(-amp)});
      n = 0;
      while (src_inst.take_cyc < 0 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 40) timeout();
      for (int k = 0; k < 160; k++) begin
         cap[k] = out_data_o;
         @(negedge clk_i);
      end
      if (!eq) begin
         lat = 0;
         while (cap[lat][31:16] === 16'h0 && lat < 100) lat++;
      end
      if (lat < 4 || lat > 97) timeout();
      for (int k = -4; k < 63; k++) begin
         cmp(cap[lat + k], {ev(k, amp, eq), ev(k, -amp, eq)});
      end
      $display("test impulse with equaliser %0d amplitude %0h done", eq, amp);
   endtask

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      int n;
      int lat;
      lat = 0;
      do_reset(iisf_pkg::IISF_X2, 1'b0, 5);
      foreach (rows[r]) begin
         src_inst.rep_val = rows[r].v;
         src_inst.rep_on = 1'b1;
         do_reset(rows[r].sel, rows[r].eq, 2);
         wait_ready(n);
         for (int p = 0; p < 4; p++) begin
            wait_ready(n);
            cmp(32'(n), 32'(2 << rows[r].sel));
         end
         repeat (1200) @(negedge clk_i);
         for (int k = 0; k < 8; k++) begin
            @(negedge clk_i);
            cmp(out_data_o, rows[r].v);
         end
         $display("test steady row %0d done", r);
      end
      // A one-cycle reset in mid-stream must clear every tap at once.
      do_reset(iisf_pkg::IISF_X2, 1'b0, 1);
      @(negedge clk_i);
      cmp({in_ready_o, out_valid_o, out_data_o[29:0]}, 32'h0);
      cmp(out_data_o, 32'h0);
      for (int k = 0; k < 4; k++) begin
         @(negedge clk_i);
         cmp({out_valid_o, out_data_o[30:0]}, 32'h80000000);
      end
      $display("test mid-stream reset done");
      run_imp(1'b0, AMP, lat);
      run_imp(1'b1, AMP, lat);
      // A full-scale impulse breaks the back-off on purpose so that the clip is exercised.
      run_imp(1'b1, 64'sh7FFF, lat);
      complete_run();
   end
endmodule
